// file: inc/uart_ctrl_pkg.sv
// Shared constants, register map and carriers for the serial port control block
package uart_ctrl_pkg;
   // Register word offsets (byte addresses on the bus)
   localparam logic [7:0] OFS_INT_ENABLE = 8'h00;
   localparam logic [7:0] OFS_DIV_LOW = 8'h04;
   localparam logic [7:0] OFS_DIV_HIGH = 8'h08;
   localparam logic [7:0] OFS_SCRATCH = 8'h0C;
   localparam logic [7:0] OFS_PORT_OPTION = 8'h10;
   localparam logic [7:0] OFS_SPEED_SELECT = 8'h14;
   localparam logic [7:0] OFS_PREDIV_SELECT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam int ADDR_LSB = 2;

   // Interrupt enable fields
   localparam int IE_RX_READY = 0;
   localparam int IE_TX_EMPTY = 1;
   localparam int IE_LINE_STATUS = 2;
   localparam int IE_MODEM_STATUS = 3;
   localparam int IE_RX_ADDR = 6;
   localparam int IE_TX_ADDR = 7;
   localparam logic [7:0] IE_WRITE_MASK = 8'hCF;

   // Port option fields
   localparam int OPT_NINE_BIT = 0;
   localparam int OPT_DIR_POLARITY = 6;
   localparam int OPT_DIR_EN = 7;
   // Speed select: high-speed when bits 7:6 are both set
   localparam int SPD_HI = 7;
   localparam int SPD_LO = 6;
   // Pre-divider select codes in bits 1:0
   localparam logic [1:0] PDIV_13 = 2'h0;
   localparam logic [1:0] PDIV_1625 = 2'h1;
   localparam logic [1:0] PDIV_1 = 2'h2;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   // 24 MHz reference synthesised from the 50 MHz system clock
   localparam longint SYS_CLK_HZ = 50_000_000;
   localparam longint REF_CLK_HZ = 24_000_000;
   localparam longint RATE_GCD = 2_000_000;
   localparam logic [7:0] REF_NUM = 8'(REF_CLK_HZ / RATE_GCD);
   localparam logic [7:0] REF_DEN = 8'(SYS_CLK_HZ / RATE_GCD);
   // Pre-divider ratios as num/den of reference ticks
   localparam logic [7:0] PD13_NUM = 8'h01;
   localparam logic [7:0] PD13_DEN = 8'h0D;
   localparam logic [7:0] PD1625_NUM = 8'h08;
   localparam logic [7:0] PD1625_DEN = 8'h0D;
   localparam logic [7:0] PD1_NUM = 8'h01;
   localparam logic [7:0] PD1_DEN = 8'h01;

   // Direction hold after the last stop bit, in 16x ticks (1.5 bit-times)
   localparam int OVERSAMPLE = 16;
   localparam logic [5:0] DIR_HOLD_TICKS = 6'(OVERSAMPLE + OVERSAMPLE / 2);

   // Interrupt identification codes
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LINE = 4'h6;
   localparam logic [3:0] IID_RX_READY = 4'h4;
   localparam logic [3:0] IID_RX_TIMEOUT = 4'hC;
   localparam logic [3:0] IID_TX_EMPTY = 4'h2;
   localparam logic [3:0] IID_MODEM = 4'h0;

   typedef struct packed {
      logic line_status;
      logic rx_ready;
      logic rx_timeout;
      logic tx_empty;
      logic modem_status;
   } irq_src_s;

   typedef struct packed {
      logic busy;
      logic bit0_start;
   } tx_state_s;

   typedef struct packed {
      logic nine_bit_en;
      logic tx_addr_byte;
      logic rx_accept_addr;
   } nine_bit_s;
endpackage : uart_ctrl_pkg

// file: core/uart_irq_baud_rs485_ctrl.sv
// Interrupt enables, baud generator, scratch and automatic RS485 direction control
//
// Functional notes
// RULE1 - Enable bit 0 gates data-ready interrupt
// RULE2 - Enable bit 1 gates transmit-empty interrupt
// RULE3 - Enable bit 2 gates line-status interrupt
// RULE4 - Enable bit 3 gates modem-status interrupt
// RULE5 - All four cleared means no interrupt
// RULE6 - Bit 7 marks transmitted byte as address
// RULE7 - Bit 6 selects receiver accepting address bytes
// RULE8 - Bits 7,6 act only in 9-bit mode
// RULE9 - Normal speed: 1.8461 MHz base over divisor
// RULE10 - Generator output is sixteen times bit rate
// RULE11 - High speed divides 24 MHz directly
// RULE12 - Pre-divider choice: 13, 1.625 or 1.0
// RULE13 - Scratch register is read/write, no effect
// RULE14 - Auto direction drives request-to-send on transmit
// RULE15 - Asserts at start-bit to bit-0 boundary
// RULE16 - Releases one to two bit-times after stop
// RULE17 - Polarity bit inverts automatic levels
// RULE18 - Enable bit 7, polarity bit 6 of options
// RULE19 - Priority: line, data/timeout, tx empty, modem
// RULE20 - Low and high bytes form 16-bit divisor
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module uart_irq_baud_rs485_ctrl (
   input wire logic sys_clk,
   input wire logic rst_n,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Interrupt sources and result
   input wire uart_ctrl_pkg::irq_src_s irq_src,
   output logic port_irq,
   output logic [3:0] irq_id,
   // Baud timing
   output logic baud16_tick,
   // 9-bit controls
   output uart_ctrl_pkg::nine_bit_s nine_bit,
   // Transmitter activity and direction pin
   input wire uart_ctrl_pkg::tx_state_s tx_state,
   input wire logic rts_manual,
   output logic rts_pin
);
   import uart_ctrl_pkg::*;

   function automatic logic [8:0] frac_step(input logic [7:0] acc, input logic [7:0] num,
                                            input logic [7:0] den);
      logic [8:0] sum;
      sum = {1'b0, acc} + {1'b0, num};
      if (sum >= {1'b0, den}) begin
         frac_step = {1'b1, 8'(sum - {1'b0, den})};
      end else begin
         frac_step = {1'b0, sum[7:0]};
      end
   endfunction : frac_step

   // Registers
   logic [7:0] int_enable_q;
   logic [7:0] div_low_q;
   logic [7:0] div_high_q;
   logic [7:0] scratch_q;
   logic [7:0] port_option_q;
   logic [7:0] speed_select_q;
   logic [7:0] prediv_select_q;
   logic ack_q;
   logic [31:0] rdata_q;

   // Bus decode
   wire logic req = wb_cyc_i & wb_stb_i;
   wire logic wr_commit = req & wb_we_i & ack_q & wb_sel_i[0];
   wire logic [7:0] wr_byte = wb_dat_i[7:0];
   wire logic hit_ie = (wb_adr_i == OFS_INT_ENABLE);
   wire logic hit_dl = (wb_adr_i == OFS_DIV_LOW);
   wire logic hit_dh = (wb_adr_i == OFS_DIV_HIGH);
   wire logic hit_sc = (wb_adr_i == OFS_SCRATCH);
   wire logic hit_po = (wb_adr_i == OFS_PORT_OPTION);
   wire logic hit_ss = (wb_adr_i == OFS_SPEED_SELECT);
   wire logic hit_ps = (wb_adr_i == OFS_PREDIV_SELECT);
   wire logic hit_st = (wb_adr_i == OFS_STATUS);

   // Interrupt gating and priority
   wire logic en_rx = int_enable_q[IE_RX_READY]; // RULE1
   wire logic en_tx = int_enable_q[IE_TX_EMPTY]; // RULE2
   wire logic en_ls = int_enable_q[IE_LINE_STATUS]; // RULE3
   wire logic en_ms = int_enable_q[IE_MODEM_STATUS]; // RULE4
   wire logic act_ls = irq_src.line_status & en_ls; // RULE3
   wire logic act_rx = irq_src.rx_ready & en_rx; // RULE1
   wire logic act_to = irq_src.rx_timeout & en_rx; // RULE1
   wire logic act_tx = irq_src.tx_empty & en_tx; // RULE2
   wire logic act_ms = irq_src.modem_status & en_ms; // RULE4
   wire logic any_irq = act_ls | act_rx | act_to | act_tx | act_ms; // RULE5
   wire logic [3:0] irq_id_d = act_ls ? IID_LINE : // RULE19
                               act_rx ? IID_RX_READY :
                               act_to ? IID_RX_TIMEOUT :
                               act_tx ? IID_TX_EMPTY :
                               act_ms ? IID_MODEM : IID_NONE;

   // Baud generator
   logic [7:0] ref_acc_q;
   logic [7:0] pd_acc_q;
   logic [15:0] div_cnt_q;
   logic baud16_q;
   wire logic [15:0] divisor = {div_high_q, div_low_q}; // RULE20
   wire logic high_speed = speed_select_q[SPD_HI] & speed_select_q[SPD_LO]; // RULE11
   wire logic [1:0] pd_sel = prediv_select_q[1:0];
   wire logic [8:0] ref_next = frac_step(ref_acc_q, REF_NUM, REF_DEN);
   wire logic ref_tick = ref_next[8];
   wire logic [7:0] pd_num = high_speed ? PD1_NUM : // RULE11
                             (pd_sel == PDIV_1625) ? PD1625_NUM : // RULE12
                             (pd_sel == PDIV_1) ? PD1_NUM : PD13_NUM; // RULE9
   wire logic [7:0] pd_den = high_speed ? PD1_DEN :
                             (pd_sel == PDIV_1625) ? PD1625_DEN :
                             (pd_sel == PDIV_1) ? PD1_DEN : PD13_DEN;
   wire logic [8:0] pd_next = frac_step(pd_acc_q, pd_num, pd_den);
   wire logic base_tick = ref_tick & pd_next[8];
   wire logic div_wrap = base_tick & (div_cnt_q + 16'h0001 >= divisor);
   wire logic baud16_d = div_wrap & (divisor != 16'h0000); // RULE10

   // Automatic direction control
   typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_HOLD} dir_state_e;
   dir_state_e dir_q;
   dir_state_e dir_d;
   logic [5:0] hold_q;
   logic [5:0] hold_d;
   wire logic dir_en = port_option_q[OPT_DIR_EN]; // RULE18
   wire logic dir_pol = port_option_q[OPT_DIR_POLARITY]; // RULE18
   wire logic dir_active = (dir_q != DIR_IDLE);
   logic rts_q;

   always_comb begin
      dir_d = dir_q;
      hold_d = hold_q;
      unique case (dir_q)
         DIR_IDLE: begin
            if (dir_en & tx_state.bit0_start) begin
               dir_d = DIR_SEND; // RULE15
            end
         end
         DIR_SEND: begin
            if (!tx_state.busy) begin
               dir_d = DIR_HOLD;
               hold_d = 6'h00;
            end
         end
         DIR_HOLD: begin
            if (tx_state.busy) begin
               dir_d = DIR_SEND;
            end else if (baud16_q) begin
               if (hold_q + 6'h01 >= DIR_HOLD_TICKS) begin
                  dir_d = DIR_IDLE; // RULE16
               end else begin
                  hold_d = hold_q + 6'h01;
               end
            end
         end
         default: begin
            dir_d = DIR_IDLE;
         end
      endcase
      if (!dir_en) begin
         dir_d = DIR_IDLE;
      end
   end

   wire logic rts_d = dir_en ? (dir_active ^ dir_pol) : rts_manual; // RULE14 RULE17

   // Read mux
   wire logic [7:0] status_byte = {3'h0, tx_state.busy, dir_active, any_irq, 2'h0};
   wire logic [7:0] rd_byte = hit_ie ? int_enable_q :
                              hit_dl ? div_low_q :
                              hit_dh ? div_high_q :
                              hit_sc ? scratch_q : // RULE13
                              hit_po ? port_option_q :
                              hit_ss ? speed_select_q :
                              hit_ps ? prediv_select_q :
                              hit_st ? status_byte : RESET_BYTE;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         int_enable_q <= RESET_BYTE;
         div_low_q <= RESET_BYTE;
         div_high_q <= RESET_BYTE;
         scratch_q <= RESET_BYTE;
         port_option_q <= RESET_BYTE;
         speed_select_q <= RESET_BYTE;
         prediv_select_q <= RESET_BYTE;
      end else if (wr_commit) begin
         if (hit_ie) int_enable_q <= wr_byte & IE_WRITE_MASK;
         if (hit_dl) div_low_q <= wr_byte; // RULE20
         if (hit_dh) div_high_q <= wr_byte; // RULE20
         if (hit_sc) scratch_q <= wr_byte; // RULE13
         if (hit_po) port_option_q <= wr_byte;
         if (hit_ss) speed_select_q <= wr_byte;
         if (hit_ps) prediv_select_q <= wr_byte;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ref_acc_q <= 8'h00;
         pd_acc_q <= 8'h00;
         div_cnt_q <= 16'h0000;
         baud16_q <= 1'b0;
      end else begin
         ref_acc_q <= ref_next[7:0];
         if (ref_tick) pd_acc_q <= pd_next[7:0]; // RULE12
         if (div_wrap) begin
            div_cnt_q <= 16'h0000; // RULE9
         end else if (base_tick) begin
            div_cnt_q <= div_cnt_q + 16'h0001;
         end
         baud16_q <= baud16_d; // RULE10
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dir_q <= DIR_IDLE;
         hold_q <= 6'h00;
         rts_q <= 1'b0;
         port_irq <= 1'b0;
         irq_id <= IID_NONE;
         nine_bit <= '0;
      end else begin
         dir_q <= dir_d;
         hold_q <= hold_d;
         rts_q <= rts_d;
         port_irq <= any_irq; // RULE5
         irq_id <= irq_id_d; // RULE19
         nine_bit.nine_bit_en <= port_option_q[OPT_NINE_BIT];
         nine_bit.tx_addr_byte <= port_option_q[OPT_NINE_BIT] & int_enable_q[IE_TX_ADDR]; // RULE6 RULE8
         nine_bit.rx_accept_addr <= port_option_q[OPT_NINE_BIT] & int_enable_q[IE_RX_ADDR]; // RULE7 RULE8
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign baud16_tick = baud16_q;
   assign rts_pin = rts_q;
endmodule : uart_irq_baud_rs485_ctrl
`default_nettype wire

// file: bench/uart_ctrl_sva.sv
// Port checker for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module uart_ctrl_sva
   import uart_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire uart_ctrl_pkg::irq_src_s irq_src,
   input wire logic port_irq,
   input wire logic [3:0] irq_id,
   input wire logic baud16_tick,
   input wire uart_ctrl_pkg::nine_bit_s nine_bit,
   input wire uart_ctrl_pkg::tx_state_s tx_state,
   input wire logic rts_manual,
   input wire logic rts_pin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_quiet;
      !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) && !$past(wb_cyc_i, 3) && $stable(rts_manual);
   endsequence
   property p_ack_resp; s_req |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause; wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i); endproperty
   property p_dat_high; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
   property p_irq_cause; port_irq |-> $past(irq_src) != 5'h00; endproperty
   property p_id_none; !port_irq |-> irq_id == IID_NONE; endproperty
   property p_nine_gate; !nine_bit.nine_bit_en |-> !nine_bit.tx_addr_byte && !nine_bit.rx_accept_addr;
   endproperty
   property p_tick_pulse; baud16_tick |=> !baud16_tick; endproperty
   property p_rts_hold;
      tx_state.busy && $past(tx_state.busy) && $past(tx_state.busy, 2) && !$past(tx_state.bit0_start)
         && !$past(tx_state.bit0_start, 2) ##0 s_quiet |-> $stable(rts_pin);
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_dat_high: assert property (p_dat_high) else $error("upper read bits set");
   a_irq_cause: assert property (p_irq_cause) else $error("irq without source");
   a_id_none: assert property (p_id_none) else $error("id without irq");
   a_nine_gate: assert property (p_nine_gate) else $error("9-bit control leaks");
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
   a_rts_hold: assert property (p_rts_hold) else $error("rts moved mid frame");
endmodule : uart_ctrl_sva
bind uart_irq_baud_rs485_ctrl uart_ctrl_sva u_sva (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_src, .port_irq, .irq_id,
   .baud16_tick, .nine_bit, .tx_state, .rts_manual, .rts_pin);
`default_nettype wire

// file: bench/uart_tx_model.sv
// Transmitter activity model: one 10-bit frame per send pulse
`timescale 1ns/10ps
`default_nettype none
module uart_tx_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic send,
   input wire logic baud16_tick,
   output var uart_ctrl_pkg::tx_state_s tx_state
);
   import uart_ctrl_pkg::*;
   logic [3:0] ticks_q;
   logic [3:0] bits_q;
   always_ff @(posedge sys_clk) begin
      tx_state.bit0_start <= 1'b0;
      if (!rst_n) begin
         tx_state.busy <= 1'b0;
      end else if (send && !tx_state.busy) begin
         tx_state.busy <= 1'b1;
         ticks_q <= 4'h0;
         bits_q <= 4'h0;
      end else if (tx_state.busy && baud16_tick) begin
         ticks_q <= ticks_q + 4'h1;
         if (ticks_q == 4'hF) begin
            bits_q <= bits_q + 4'h1;
            tx_state.bit0_start <= (bits_q == 4'h0);
            tx_state.busy <= (bits_q != 4'h9);
         end
      end
   end
endmodule : uart_tx_model
`default_nettype wire

// file: bench/uart_irq_baud_rs485_ctrl_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module uart_irq_baud_rs485_ctrl_bench;
   import uart_ctrl_pkg::*;
   logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, send = 0, manual = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h1;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, port_irq, tick, rts;
   logic [3:0] irq_id;
   irq_src_s src = '0;
   nine_bit_s nb;
   tx_state_s txs;
   int compares = 0, miscompares = 0;
   uart_irq_baud_rs485_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_src(src), .port_irq(port_irq), .irq_id(irq_id),
      .baud16_tick(tick), .nine_bit(nb), .tx_state(txs), .rts_manual(manual), .rts_pin(rts));
   uart_tx_model u_tx (.sys_clk(sys_clk), .rst_n(rst_n), .send(send), .baud16_tick(tick),
      .tx_state(txs));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
      @(posedge sys_clk);
      while (ack !== 1'b1) @(posedge sys_clk);
      q = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : bus
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK("reg", e, q)
   endtask : rd_chk
   task t_regs;
      rd_chk(OFS_INT_ENABLE, 8'h00); rd_chk(OFS_DIV_LOW, 8'h00); rd_chk(OFS_SCRATCH, 8'h00);
      wr(OFS_INT_ENABLE, 8'hFF); rd_chk(OFS_INT_ENABLE, IE_WRITE_MASK);
      wr(OFS_SCRATCH, 8'hA5); rd_chk(OFS_SCRATCH, 8'hA5);
      sel <= 4'h0; wr(OFS_SCRATCH, 8'h5A); sel <= 4'h1;
      rd_chk(OFS_SCRATCH, 8'hA5);
      rd_chk(OFS_STATUS, 8'h00);
      wr(OFS_DIV_HIGH, 8'h5A); rd_chk(OFS_DIV_HIGH, 8'h5A);
      wr(8'h20, 8'h77); rd_chk(8'h20, 8'h00);
      $display("test regs done");
   endtask : t_regs
   task t_irq;
      logic [4:0] s [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
      logic [7:0] m [5] = '{8'h04, 8'h01, 8'h01, 8'h02, 8'h08};
      logic [3:0] id [5] = '{IID_LINE, IID_RX_READY, IID_RX_TIMEOUT, IID_TX_EMPTY, IID_MODEM};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_INT_ENABLE, m[i]); src <= s[i]; repeat (3) @(posedge sys_clk); #1;
         `CHK("irq", 1'b1, port_irq)
         `CHK("id", id[i], irq_id)
         wr(OFS_INT_ENABLE, ~m[i] & 8'h0F); repeat (3) @(posedge sys_clk); #1;
         `CHK("masked", 1'b0, port_irq)
      end
      src <= 5'h1F; wr(OFS_INT_ENABLE, 8'h00); repeat (3) @(posedge sys_clk); #1;
      `CHK("none", 1'b0, port_irq)
      wr(OFS_INT_ENABLE, 8'h0F); src <= 5'h0F; repeat (3) @(posedge sys_clk); #1;
      `CHK("prio", IID_RX_READY, irq_id)
      src <= 5'h00;
      $display("test irq done");
   endtask : t_irq
   task t_nine;
      wr(OFS_PORT_OPTION, 8'h00); wr(OFS_INT_ENABLE, 8'hC0); repeat (2) @(posedge sys_clk); #1;
      `CHK("nine off", 3'b000, nb)
      wr(OFS_PORT_OPTION, 8'h01); repeat (2) @(posedge sys_clk); #1;
      `CHK("nine both", 3'b111, nb)
      wr(OFS_INT_ENABLE, 8'h80); repeat (2) @(posedge sys_clk); #1;
      `CHK("nine tx", 3'b110, nb)
      $display("test nine done");
   endtask : t_nine
   task rate(input logic [7:0] pd, input logic [7:0] sp, input logic [15:0] dv, input int n,
      input int e);
      int c;
      wr(OFS_PREDIV_SELECT, pd); wr(OFS_SPEED_SELECT, sp);
      wr(OFS_DIV_LOW, dv[7:0]); wr(OFS_DIV_HIGH, dv[15:8]);
      c = 0;
      repeat (n) begin @(posedge sys_clk); #1; if (tick === 1'b1) c++; end
      `CHK("rate", 1'b1, (c >= e - 1 && c <= e + 1))
   endtask : rate
   task t_baud;
      rate(8'h02, 8'h00, 16'h0001, 1000, 480);
      rate(8'h00, 8'h00, 16'h0001, 2600, 96);
      rate(8'h01, 8'h00, 16'h0008, 6500, 240);
      rate(8'h00, 8'hC0, 16'h0002, 1000, 240);
      rate(8'h02, 8'h00, 16'h0100, 10667, 20);
      $display("test baud done");
   endtask : t_baud
   task frame(input logic on);
      int c;
      @(posedge sys_clk); send <= 1'b1; @(posedge sys_clk); send <= 1'b0;
      while (txs.bit0_start !== 1'b1) begin #1; `CHK("pre", ~on, rts) @(posedge sys_clk); end
      repeat (3) @(posedge sys_clk); #1;
      `CHK("send", on, rts)
      while (txs.busy === 1'b1) @(posedge sys_clk);
      c = 0;
      while (rts === on && c < 40) begin @(posedge sys_clk); #1; if (tick === 1'b1) c++; end
      `CHK("hold", 1'b1, (c >= 16 && c <= 32))
   endtask : frame
   task t_rts;
      wr(OFS_PREDIV_SELECT, 8'h02); wr(OFS_DIV_LOW, 8'h01); wr(OFS_DIV_HIGH, 8'h00);
      wr(OFS_PORT_OPTION, 8'h80); frame(1'b1);
      wr(OFS_PORT_OPTION, 8'hC0); frame(1'b0);
      manual <= 1'b1; wr(OFS_PORT_OPTION, 8'h00); send <= 1'b1;
      repeat (60) begin @(posedge sys_clk); send <= 1'b0; #1; `CHK("manual", 1'b1, rts) end
      $display("test rts done");
   endtask : t_rts
   task close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   initial begin
      #1000000;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs(); t_irq(); t_nine(); t_baud(); t_rts();
      close_out();
   end
endmodule : uart_irq_baud_rs485_ctrl_bench
`default_nettype wire
